// ===== hw/dspacs_pkg.sv
/*
 * Shared constants and types of the signal-processing extension state:
 * control/status register layout, reset value, operation classes and
 * the exception code. Assumes a single 32-bit control register.
 */
package dspacs_pkg;
    // Control/status register as a whole
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    // Implemented bits: 27:16, 14:7, 5:0; everything else reads zero
    localparam logic [31:0] CTL_IMPL_MASK = 32'h0FFF_7FBF;
    // Field positions
    localparam int COND_LSB = 24;
    localparam int COND_W = 4;
    localparam int OUF_LSB = 16;
    localparam int OUF_W = 8;
    localparam int OUF_ACC_BASE = 0;
    localparam int OUF_ADDSUB = 4;
    localparam int OUF_MUL = 5;
    localparam int OUF_SHIFT = 6;
    localparam int OUF_EXTR = 7;
    localparam int XFAIL_BIT = 14;
    localparam int CARRY_BIT = 13;
    localparam int INS_SIZE_LSB = 7;
    localparam int POS_LSB = 0;
    localparam int FIELD6_W = 6;
    // Position step of the low-to-high move
    localparam logic [5:0] POS_STEP_LOHI = 6'h20;
    // Cause code of the state-disabled exception
    localparam logic [4:0] EXC_CODE_DISABLED = 5'h1A;
    localparam logic [4:0] EXC_CODE_NONE = 5'h00;
    // Number of accumulator pairs
    localparam int NUM_ACC = 4;

    // Operation classes issued by the pipeline
    typedef enum logic [4:0] {
        DSPACS_OP_NONE   = 5'b00000,
        DSPACS_OP_WRCTL  = 5'b00001,
        DSPACS_OP_CMP    = 5'b00010,
        DSPACS_OP_DPMAC  = 5'b00011,
        DSPACS_OP_ADDSUB = 5'b00100,
        DSPACS_OP_ADDSETC = 5'b00101,
        DSPACS_OP_ADDCIN = 5'b00110,
        DSPACS_OP_MUL    = 5'b00111,
        DSPACS_OP_SHIFT  = 5'b01000,
        DSPACS_OP_EXTR   = 5'b01001,
        DSPACS_OP_XPOS = 5'b01010,
        DSPACS_OP_XPOSDEC = 5'b01011,
        DSPACS_OP_INSVAR = 5'b01100,
        DSPACS_OP_LOHIMV = 5'b01101,
        DSPACS_OP_MTACC  = 5'b01110,
        DSPACS_OP_MFACC  = 5'b01111,
        DSPACS_OP_RDCTL  = 5'b10000
    } dspacs_op_t;
endpackage

// ===== hw/dspacs_acc_if.sv
/*
 * Carrier between the control logic and the accumulator storage.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/100ps
interface dspacs_acc_if;
    logic [1:0] sel;       // Selected accumulator pair
    logic we_hi;           // Write high word
    logic we_lo;           // Write low word
    logic copy_lo;         // Copy low word into high word
    logic [31:0] wdata_hi; // High write data
    logic [31:0] wdata_lo; // Low write data
    logic [31:0] rdata_hi; // Registered high read data
    logic [31:0] rdata_lo; // Registered low read data
    modport ctl (output sel, we_hi, we_lo, copy_lo, wdata_hi, wdata_lo,
                 input rdata_hi, rdata_lo);
    modport mem (input sel, we_hi, we_lo, copy_lo, wdata_hi, wdata_lo,
                 output rdata_hi, rdata_lo);
endinterface

// ===== hw/dspacs_acc_mem.sv
/*
 * Four high/low accumulator pairs with a registered read port.
 * Assumes at most one write request per cycle from the control logic.
 */
`timescale 1ns/100ps
module dspacs_acc_mem (
    input wire logic clk,
    input wire logic rst_b,
    dspacs_acc_if.mem acc
);
    logic [31:0] hi_a [dspacs_pkg::NUM_ACC]; // Current high words
    logic [31:0] lo_a [dspacs_pkg::NUM_ACC]; // Current low words
    logic [31:0] rd_hi, rd_lo, next_rd_hi, next_rd_lo;

    // One storage pair per accumulator
    for (genvar i = 0; i < dspacs_pkg::NUM_ACC; i++) begin : g_pair
        logic [31:0] hi, lo, next_hi, next_lo;
        always_comb begin
            next_hi = hi;
            next_lo = lo;
            if (acc.sel == 2'(i)) begin
                // Copy reads the old low word, so a same-cycle low write is safe
                if (acc.copy_lo) begin
                    next_hi = lo;
                end else if (acc.we_hi) begin
                    next_hi = acc.wdata_hi;
                end
                if (acc.we_lo) begin
                    next_lo = acc.wdata_lo;
                end
            end
        end
        always_ff @(posedge clk or negedge rst_b) begin
            if (!rst_b) begin
                hi <= 32'h0000_0000;
                lo <= 32'h0000_0000;
            end else begin
                hi <= next_hi;
                lo <= next_lo;
            end
        end
        assign hi_a[i] = hi;
        assign lo_a[i] = lo;
    end

    // Read is old data: a write shows one cycle later
    always_comb begin
        next_rd_hi = hi_a[acc.sel];
        next_rd_lo = lo_a[acc.sel];
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_hi <= 32'h0000_0000;
            rd_lo <= 32'h0000_0000;
        end else begin
            rd_hi <= next_rd_hi;
            rd_lo <= next_rd_lo;
        end
    end
    assign acc.rdata_hi = rd_hi;
    assign acc.rdata_lo = rd_lo;
endmodule // dspacs_acc_mem

// ===== hw/dspacs_pos_unit.sv
/*
 * Position arithmetic for extract and the low-to-high move: failure test and the
 * decremented and incremented bit-index. Purely combinational.
 */
`timescale 1ns/100ps
module dspacs_pos_unit (
    input wire logic [5:0] pos,
    input wire logic [5:0] size,
    output logic fail,
    output logic [5:0] pos_dec,
    output logic [5:0] pos_inc
);
    // Too few bits left below the index
    assign fail = (pos < size); // RULE_11
    // Wraps modulo 64; only used when the extract succeeded
    assign pos_dec = pos - size; // RULE_15
    assign pos_inc = pos + dspacs_pkg::POS_STEP_LOHI; // RULE_16
endmodule // dspacs_pos_unit

// ===== hw/dspacs_state.sv
/*
 * Architectural state of the signal-processing extension: control and
 * status register, accumulator pairs, enable check and presence flags.
 * Assumes the pipeline issues at most one operation per cycle, already
 * decoded to an operation class, with overflow and carry results
 * computed by the datapath in the same cycle.
 */
// Functional notes
// (RULE_01) Four accumulator pairs, selected by two bits
// (RULE_02) Bits 31:28 always read zero
// (RULE_03) Compare writes only low condition bits
// (RULE_04) Overflow flags sticky, cleared by control write
// (RULE_05) Dot/MAC overflow sets flag of accumulator
// (RULE_06) Add/subtract/abs overflow sets flag 20
// (RULE_07) Vector multiply overflow sets flag 21
// (RULE_08) Precision reduce and left shift: flag 22
// (RULE_09) Accumulator extract overflow sets flag 23
// (RULE_10) Extract-fail flag rewritten by every extract; the accumulator extract (DSPACS_OP_EXTR) leaves it alone here
// (RULE_11) Extract fails when index below size
// (RULE_12) Carry written by add-set, read by add-with
// (RULE_13) Insert width comes from size field
// (RULE_14) Index field gives insert and extract position
// (RULE_15) Decrementing extract lowers index by size
// (RULE_16) Low-to-high move copies, index plus 32
// (RULE_17) Disabled extension raises exception code 26
// (RULE_18) Presence flags fixed at build time
// (RULE_19) Reset zero; writes ignore reserved bits
`timescale 1ns/100ps
module dspacs_state #(
    parameter logic PRESENT = 1'b1, // Build-time presence of the extension
    parameter logic REV2_PRESENT = 1'b1 // Build-time presence of revision 2
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic instr_valid,
    input dspacs_pkg::dspacs_op_t instr_op,
    input wire logic [1:0] acc_sel,
    input wire logic ovf_event,
    input wire logic [3:0] cmp_bits,
    input wire logic [2:0] cmp_count,
    input wire logic [5:0] extract_size,
    input wire logic carry_result,
    input wire logic [31:0] ctl_wdata,
    input wire logic acc_wr_hi,
    input wire logic acc_wr_lo,
    input wire logic [31:0] acc_wdata_hi,
    input wire logic [31:0] acc_wdata_lo,
    input wire logic extension_enable_bit,
    output logic [31:0] ctl_status,
    output logic carry_bit,
    output logic [5:0] insert_size,
    output logic [5:0] insert_pos,
    output logic [31:0] acc_rdata_hi,
    output logic [31:0] acc_rdata_lo,
    output logic extension_present_flag,
    output logic extension_rev2_present_flag,
    output logic exc_valid,
    output logic [4:0] exc_code
);
    logic [31:0] ctl, next_ctl;       // Control/status register
    logic exc_q, next_exc_q;          // Exception pulse
    logic [4:0] code_q, next_code_q;  // Exception cause
    logic accepted;                   // Any extension operation offered
    logic go;                         // Operation allowed to act
    logic disabled_hit;               // Operation blocked by enable
    logic ext_fail;                   // Extract failure of this operation
    logic [5:0] pos_dec, pos_inc;     // Updated index candidates
    logic [3:0] cond_code, cm; // Condition codes and compare mask
    logic [7:0] ouf; // Sticky overflow flags
    logic xfail; // Extract-fail flag
    logic [5:0] ins_size, pos; // Insert size and bit index

    dspacs_acc_if acc_bus ();

    // Compare writes the lowest bits, one per vector element
    function automatic logic [3:0] cmp_mask(input logic [2:0] n);
        case (n)
            3'h1: cmp_mask = 4'h1;
            3'h2: cmp_mask = 4'h3;
            3'h3: cmp_mask = 4'h7;
            3'h4: cmp_mask = 4'hF;
            default: cmp_mask = 4'h0;
        endcase
    endfunction

    // Only dot/MAC and the accumulator move may write words
    function automatic logic acc_write_class(input dspacs_pkg::dspacs_op_t op);
        acc_write_class = (op == dspacs_pkg::DSPACS_OP_DPMAC) ||
            (op == dspacs_pkg::DSPACS_OP_MTACC);
    endfunction

    // Field views of the register
    assign cond_code = ctl[dspacs_pkg::COND_LSB +: dspacs_pkg::COND_W];
    assign ouf = ctl[dspacs_pkg::OUF_LSB +: dspacs_pkg::OUF_W];
    assign xfail = ctl[dspacs_pkg::XFAIL_BIT];
    assign ins_size = ctl[dspacs_pkg::INS_SIZE_LSB +: dspacs_pkg::FIELD6_W];
    assign pos = ctl[dspacs_pkg::POS_LSB +: dspacs_pkg::FIELD6_W];
    assign cm = cmp_mask(cmp_count);

    // Enable gate: a blocked operation changes no state
    assign accepted = instr_valid && (instr_op != dspacs_pkg::DSPACS_OP_NONE);
    assign disabled_hit = accepted && !extension_enable_bit; // RULE_17
    assign go = accepted && extension_enable_bit;

    dspacs_pos_unit u_pos (
        .pos(pos),
        .size(extract_size),
        .fail(ext_fail),
        .pos_dec(pos_dec),
        .pos_inc(pos_inc)
    );

    // Next register value and exception for the offered operation
    always_comb begin
        next_ctl = ctl;
        next_exc_q = 1'b0;
        next_code_q = dspacs_pkg::EXC_CODE_NONE;
        if (disabled_hit) begin
            // Trap instead of acting; nothing else moves
            next_exc_q = 1'b1; // RULE_17
            next_code_q = dspacs_pkg::EXC_CODE_DISABLED; // RULE_17
        end else if (go) begin
            case (instr_op)
                dspacs_pkg::DSPACS_OP_WRCTL: begin
                    // Only path that clears overflow flags
                    next_ctl = ctl_wdata; // RULE_04
                end
                dspacs_pkg::DSPACS_OP_CMP: begin
                    next_ctl[dspacs_pkg::COND_LSB +: dspacs_pkg::COND_W] =
                        (cond_code & ~cm) | (cmp_bits & cm); // RULE_03
                end
                dspacs_pkg::DSPACS_OP_DPMAC: begin
                    if (ovf_event) begin
                        next_ctl[dspacs_pkg::OUF_LSB + dspacs_pkg::OUF_ACC_BASE
                                 + int'(acc_sel)] = 1'b1; // RULE_05
                    end
                end
                dspacs_pkg::DSPACS_OP_ADDSUB: begin
                    if (ovf_event) begin
                        next_ctl[dspacs_pkg::OUF_LSB + dspacs_pkg::OUF_ADDSUB] = 1'b1; // RULE_06
                    end
                end
                dspacs_pkg::DSPACS_OP_ADDSETC: begin
                    next_ctl[dspacs_pkg::CARRY_BIT] = carry_result; // RULE_12
                end
                dspacs_pkg::DSPACS_OP_ADDCIN: begin
                    // Consumes carry_bit; belongs to the add overflow class
                    if (ovf_event) begin
                        next_ctl[dspacs_pkg::OUF_LSB + dspacs_pkg::OUF_ADDSUB] = 1'b1; // RULE_06
                    end
                end
                dspacs_pkg::DSPACS_OP_MUL: begin
                    if (ovf_event) begin
                        next_ctl[dspacs_pkg::OUF_LSB + dspacs_pkg::OUF_MUL] = 1'b1; // RULE_07
                    end
                end
                dspacs_pkg::DSPACS_OP_SHIFT: begin
                    if (ovf_event) begin
                        next_ctl[dspacs_pkg::OUF_LSB + dspacs_pkg::OUF_SHIFT] = 1'b1; // RULE_08
                    end
                end
                dspacs_pkg::DSPACS_OP_EXTR: begin
                    if (ovf_event) begin
                        next_ctl[dspacs_pkg::OUF_LSB + dspacs_pkg::OUF_EXTR] = 1'b1; // RULE_09
                    end
                end
                dspacs_pkg::DSPACS_OP_XPOS: begin
                    next_ctl[dspacs_pkg::XFAIL_BIT] = ext_fail; // RULE_10
                end
                dspacs_pkg::DSPACS_OP_XPOSDEC: begin
                    next_ctl[dspacs_pkg::XFAIL_BIT] = ext_fail; // RULE_10
                    // A failed extract leaves the index where it was
                    if (!ext_fail) begin
                        next_ctl[dspacs_pkg::POS_LSB +: dspacs_pkg::FIELD6_W] = pos_dec; // RULE_15
                    end
                end
                dspacs_pkg::DSPACS_OP_LOHIMV: begin
                    next_ctl[dspacs_pkg::POS_LSB +: dspacs_pkg::FIELD6_W] = pos_inc; // RULE_16
                end
                default: begin
                    // Insert, accumulator moves and reads leave the register alone
                    next_ctl = ctl;
                end
            endcase
        end
        // Reserved positions never hold a one
        next_ctl = next_ctl & dspacs_pkg::CTL_IMPL_MASK; // RULE_02 RULE_19
    end

    // Register stage for control state and exception
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ctl <= dspacs_pkg::CTL_RESET; // RULE_19
            exc_q <= 1'b0;
            code_q <= dspacs_pkg::EXC_CODE_NONE;
        end else begin
            ctl <= next_ctl;
            exc_q <= next_exc_q;
            code_q <= next_code_q;
        end
    end

    // Accumulator requests: destination from the two-bit select
    assign acc_bus.sel = acc_sel; // RULE_01
    assign acc_bus.we_hi = go && acc_wr_hi && acc_write_class(instr_op);
    assign acc_bus.we_lo = go && acc_wr_lo && acc_write_class(instr_op);
    assign acc_bus.copy_lo = go && (instr_op == dspacs_pkg::DSPACS_OP_LOHIMV); // RULE_16
    assign acc_bus.wdata_hi = acc_wdata_hi;
    assign acc_bus.wdata_lo = acc_wdata_lo;

    dspacs_acc_mem u_acc (
        .clk(clk),
        .rst_b(rst_b),
        .acc(acc_bus)
    );

    // Outputs
    assign ctl_status = ctl;
    assign carry_bit = ctl[dspacs_pkg::CARRY_BIT]; // RULE_12
    assign insert_size = ins_size; // RULE_13
    assign insert_pos = pos; // RULE_14
    assign acc_rdata_hi = acc_bus.rdata_hi;
    assign acc_rdata_lo = acc_bus.rdata_lo;
    assign extension_present_flag = PRESENT; // RULE_18
    assign extension_rev2_present_flag = REV2_PRESENT; // RULE_18
    assign exc_valid = exc_q;
    assign exc_code = code_q;

    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_rsv_zero;
        (ctl & ~dspacs_pkg::CTL_IMPL_MASK) == 32'h0000_0000;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bit set"); // RULE_02

    property p_cmp_low;
        go && instr_op == dspacs_pkg::DSPACS_OP_CMP && cmp_count == 3'h2
        |=> cond_code[1:0] == $past(cmp_bits[1:0]) && cond_code[3:2] == $past(cond_code[3:2]);
    endproperty
    a_cmp_low: assert property (p_cmp_low) else $error("compare bits wrong"); // RULE_03

    property p_ouf_sticky;
        !(go && instr_op == dspacs_pkg::DSPACS_OP_WRCTL)
        |=> (ouf & $past(ouf)) == $past(ouf);
    endproperty
    a_ouf_sticky: assert property (p_ouf_sticky) else $error("flag cleared"); // RULE_04

    property p_acc_flag;
        go && instr_op == dspacs_pkg::DSPACS_OP_DPMAC && ovf_event && acc_sel == 2'h3
        |=> ouf[3];
    endproperty
    a_acc_flag: assert property (p_acc_flag) else $error("acc flag not set"); // RULE_05

    property p_class_flag;
        go && ovf_event && (instr_op == dspacs_pkg::DSPACS_OP_ADDCIN ||
                            instr_op == dspacs_pkg::DSPACS_OP_ADDSUB)
        |=> ouf[4];
    endproperty
    a_class_flag: assert property (p_class_flag) else $error("class flag"); // RULE_06

    // Multiply overflow lands in its own flag
    property p_mul_flag;
        go && ovf_event && instr_op == dspacs_pkg::DSPACS_OP_MUL |=> ouf[5];
    endproperty
    a_mul_flag: assert property (p_mul_flag) else $error("multiply flag"); // RULE_07

    // Accumulator extract overflow lands in the top flag
    property p_xtr_flag;
        go && ovf_event && instr_op == dspacs_pkg::DSPACS_OP_EXTR |=> ouf[7];
    endproperty
    a_xtr_flag: assert property (p_xtr_flag) else $error("extract flag"); // RULE_09

    property p_efi;
        go && (instr_op == dspacs_pkg::DSPACS_OP_XPOS ||
               instr_op == dspacs_pkg::DSPACS_OP_XPOSDEC)
        |=> xfail == ($past(pos) < $past(extract_size));
    endproperty
    a_efi: assert property (p_efi) else $error("extract flag wrong"); // RULE_10

    property p_carry;
        go && instr_op == dspacs_pkg::DSPACS_OP_ADDSETC |=> carry_bit == $past(carry_result);
    endproperty
    a_carry: assert property (p_carry) else $error("carry not written"); // RULE_12

    property p_pos_dec;
        go && instr_op == dspacs_pkg::DSPACS_OP_XPOSDEC && pos >= extract_size
        |=> pos == $past(pos) - $past(extract_size);
    endproperty
    a_pos_dec: assert property (p_pos_dec) else $error("index not lowered"); // RULE_15

    property p_lohi_move;
        go && instr_op == dspacs_pkg::DSPACS_OP_LOHIMV
        |=> pos == $past(pos) + dspacs_pkg::POS_STEP_LOHI;
    endproperty
    a_lohi_move: assert property (p_lohi_move) else $error("index not raised"); // RULE_16

    property p_disabled;
        disabled_hit |=> exc_valid && exc_code == 5'h1A && ctl == $past(ctl);
    endproperty
    a_disabled: assert property (p_disabled) else $error("no disabled exception"); // RULE_17

    cover property (go && instr_op == dspacs_pkg::DSPACS_OP_XPOS && ext_fail);
    cover property (disabled_hit ##1 exc_valid);
    cover property (go && instr_op == dspacs_pkg::DSPACS_OP_LOHIMV);
    cover property (go && instr_op == dspacs_pkg::DSPACS_OP_DPMAC && ovf_event);
endmodule // dspacs_state

// ===== testbench/dspacs_pipe_model.sv
/* Behavioural model of the core pipeline that issues extension operations.
   Assumes one caller process, at most one call per clock cycle. */
`timescale 1ns/100ps
module dspacs_pipe_model (
    input wire logic clk,
    output logic instr_valid,
    output dspacs_pkg::dspacs_op_t instr_op,
    output logic [1:0] acc_sel,
    output logic ovf_event,
    output logic [3:0] cmp_bits,
    output logic [2:0] cmp_count,
    output logic [5:0] extract_size,
    output logic carry_result,
    output logic [31:0] ctl_wdata,
    output logic acc_wr_hi,
    output logic acc_wr_lo,
    output logic [31:0] acc_wdata_hi,
    output logic [31:0] acc_wdata_lo,
    output logic extension_enable_bit
);
    logic [31:0] dq; // One operand word; each field is a slice of it, acc_wdata_hi its inverse
    // Slices keep the call short; bits 28 and 29 request accumulator writes
    assign ctl_wdata = dq;
    assign acc_wdata_lo = dq;
    assign acc_wdata_hi = ~dq;
    assign cmp_bits = dq[3:0];
    assign cmp_count = dq[10:8];
    assign extract_size = dq[21:16];
    assign carry_result = dq[24];
    assign acc_wr_hi = dq[28];
    assign acc_wr_lo = dq[29];
    // Quiet pipeline at time zero
    initial begin
        instr_valid = 1'b0;
        instr_op = dspacs_pkg::DSPACS_OP_NONE;
        acc_sel = 2'h0;
        ovf_event = 1'b0;
        dq = 32'h0000_0000;
        extension_enable_bit = 1'b1;
    end
    // Offer one operation just after an edge; the next edge takes it
    task automatic issue(input logic [4:0] op, input logic [1:0] sel, input logic ovf,
                         input logic [31:0] d, input logic en);
        @(posedge clk);
        #1;
        instr_valid = 1'b1;
        instr_op = dspacs_pkg::dspacs_op_t'(op);
        acc_sel = sel;
        ovf_event = ovf;
        dq = d;
        extension_enable_bit = en;
    endtask
    // Withdraw; ovf_event and the operand word flip so a stale value of them cannot pass for a good one; acc_sel and the enable hold
    task automatic idle();
        @(posedge clk);
        #1;
        instr_valid = 1'b0;
        instr_op = dspacs_pkg::DSPACS_OP_NONE;
        ovf_event = ~ovf_event;
        dq = ~dq;
    endtask
endmodule // dspacs_pipe_model

// ===== testbench/tb_dsp_accumulator_control_state.sv
/* Self-checking bench of the extension state block.
   Assumes the pipeline model drives every operation input. */
`timescale 1ns/100ps
module tb_dsp_accumulator_control_state;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic instr_valid, ovf_event, carry_result, acc_wr_hi, acc_wr_lo, extension_enable_bit;
    dspacs_pkg::dspacs_op_t instr_op;
    logic [1:0] acc_sel;
    logic [3:0] cmp_bits;
    logic [2:0] cmp_count;
    logic [5:0] extract_size, insert_size, insert_pos;
    logic [31:0] ctl_wdata, acc_wdata_hi, acc_wdata_lo, ctl_status, acc_rdata_hi, acc_rdata_lo;
    logic carry_bit, extension_present_flag, extension_rev2_present_flag, exc_valid;
    logic [4:0] exc_code;
    int mismatches = 0;
    int tests_run = 0;
    // One operation and the register value expected after it
    typedef struct {logic [4:0] op; logic [1:0] sel; logic ovf; logic [31:0] d;
                    logic [31:0] e;} dspacs_row_t;
    dspacs_row_t rows [27];
    logic [4:0] dis_ops [5] = '{5'h01, 5'h02, 5'h03, 5'h0E, 5'h0F}; // Tried while disabled

    // 100 MHz core clock
    always #5 clk = ~clk;

    dspacs_pipe_model pipe (.clk(clk), .instr_valid(instr_valid), .instr_op(instr_op),
        .acc_sel(acc_sel), .ovf_event(ovf_event), .cmp_bits(cmp_bits),
        .cmp_count(cmp_count), .extract_size(extract_size), .carry_result(carry_result),
        .ctl_wdata(ctl_wdata), .acc_wr_hi(acc_wr_hi), .acc_wr_lo(acc_wr_lo),
        .acc_wdata_hi(acc_wdata_hi), .acc_wdata_lo(acc_wdata_lo),
        .extension_enable_bit(extension_enable_bit));

    // Revision flag built absent so a stuck constant shows
    dspacs_state #(.PRESENT(1'b1), .REV2_PRESENT(1'b0)) uut (.clk(clk), .rst_b(rst_b),
        .instr_valid(instr_valid), .instr_op(instr_op), .acc_sel(acc_sel),
        .ovf_event(ovf_event), .cmp_bits(cmp_bits), .cmp_count(cmp_count),
        .extract_size(extract_size), .carry_result(carry_result), .ctl_wdata(ctl_wdata),
        .acc_wr_hi(acc_wr_hi), .acc_wr_lo(acc_wr_lo), .acc_wdata_hi(acc_wdata_hi),
        .acc_wdata_lo(acc_wdata_lo), .extension_enable_bit(extension_enable_bit),
        .ctl_status(ctl_status), .carry_bit(carry_bit), .insert_size(insert_size),
        .insert_pos(insert_pos), .acc_rdata_hi(acc_rdata_hi), .acc_rdata_lo(acc_rdata_lo),
        .extension_present_flag(extension_present_flag),
        .extension_rev2_present_flag(extension_rev2_present_flag),
        .exc_valid(exc_valid), .exc_code(exc_code));

    // Count a comparison and report a mismatch at once
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask

    // Register and the outputs that mirror its fields
    task automatic chk_ctl(input logic [31:0] e);
        cmp("ctl_status", e, ctl_status);
        cmp("carry_bit", {31'h0, e[13]}, {31'h0, carry_bit});
        cmp("insert_size", {26'h0, e[12:7]}, {26'h0, insert_size});
        cmp("insert_pos", {26'h0, e[5:0]}, {26'h0, insert_pos});
        cmp("exc_valid", 32'h0, {31'h0, exc_valid});
    endtask

    // Accumulator read port
    task automatic chk_acc(input logic [31:0] h, input logic [31:0] l);
        cmp("acc_rdata_hi", h, acc_rdata_hi);
        cmp("acc_rdata_lo", l, acc_rdata_lo);
    endtask

    // Single closing point of the run
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Hang guard: far beyond the roughly 60 cycles the run needs
    initial begin
        #200000;
        mismatches++;
        give_verdict();
    end

    // Main sequence
    initial begin
        rows = '{
            '{5'h01, 2'd0, 1'b0, 32'hFFFF_FFFF, 32'h0FFF_7FBF},
            '{5'h01, 2'd0, 1'b0, 32'h0, 32'h0},
            '{5'h03, 2'd0, 1'b1, 32'h0, 32'h0001_0000},
            '{5'h03, 2'd1, 1'b1, 32'h0, 32'h0003_0000},
            '{5'h03, 2'd2, 1'b0, 32'h0, 32'h0003_0000},
            '{5'h03, 2'd2, 1'b1, 32'h0, 32'h0007_0000},
            '{5'h03, 2'd3, 1'b1, 32'h0, 32'h000F_0000},
            '{5'h06, 2'd0, 1'b1, 32'h0, 32'h001F_0000},
            '{5'h04, 2'd0, 1'b0, 32'h0, 32'h001F_0000},
            '{5'h07, 2'd0, 1'b1, 32'h0, 32'h003F_0000},
            '{5'h08, 2'd0, 1'b1, 32'h0, 32'h007F_0000},
            '{5'h09, 2'd0, 1'b1, 32'h0, 32'h00FF_0000},
            '{5'h02, 2'd0, 1'b0, 32'h0205, 32'h01FF_0000},
            '{5'h02, 2'd0, 1'b0, 32'h040F, 32'h0FFF_0000},
            '{5'h02, 2'd0, 1'b0, 32'h0100, 32'h0EFF_0000},
            '{5'h05, 2'd0, 1'b0, 32'h0100_0000, 32'h0EFF_2000},
            '{5'h01, 2'd0, 1'b0, 32'h028A, 32'h028A},
            '{5'h0A, 2'd0, 1'b0, 32'h0004_0000, 32'h028A},
            '{5'h0B, 2'd0, 1'b0, 32'h0004_0000, 32'h0286},
            '{5'h0B, 2'd0, 1'b0, 32'h0007_0000, 32'h4286},
            '{5'h0A, 2'd0, 1'b0, 32'h0006_0000, 32'h0286},
            '{5'h0B, 2'd0, 1'b0, 32'h0006_0000, 32'h0280},
            '{5'h0D, 2'd0, 1'b0, 32'h0, 32'h02A0},
            '{5'h0D, 2'd0, 1'b0, 32'h0, 32'h0280},
            '{5'h0C, 2'd0, 1'b0, 32'h0, 32'h0280},
            '{5'h10, 2'd0, 1'b0, 32'h0, 32'h0280},
            '{5'h04, 2'd0, 1'b1, 32'h0, 32'h0010_0280}
        };
        repeat (5) @(posedge clk);
        #1;
        rst_b = 1'b1;
        chk_ctl(32'h0);
        chk_acc(32'h0, 32'h0);
        cmp("present", 32'h1, {31'h0, extension_present_flag});
        cmp("rev2_present", 32'h0, {31'h0, extension_rev2_present_flag});
        // Rows go back to back; each result is seen while the next op is offered
        for (int i = 0; i < 27; i++) begin
            pipe.issue(rows[i].op, rows[i].sel, rows[i].ovf, rows[i].d, 1'b1);
            if (i > 0) begin
                chk_ctl(rows[i - 1].e);
            end
        end
        pipe.idle();
        chk_ctl(rows[26].e);
        // Both words of pair 2, then a write request on a class that may not write
        pipe.issue(5'h0E, 2'd2, 1'b0, 32'h3000_1234, 1'b1);
        pipe.idle();
        pipe.idle();
        chk_acc(32'hCFFF_EDCB, 32'h3000_1234);
        pipe.issue(5'h04, 2'd1, 1'b0, 32'h3000_5555, 1'b1);
        pipe.idle();
        pipe.idle();
        chk_acc(32'h0, 32'h0);
        pipe.issue(5'h0D, 2'd2, 1'b0, 32'h0, 1'b1);
        pipe.idle();
        pipe.idle();
        chk_acc(32'h3000_1234, 32'h3000_1234);
        chk_ctl(32'h0010_02A0);
        // Disabled extension: a one-cycle exception and no state change
        foreach (dis_ops[k]) begin
            pipe.issue(dis_ops[k], 2'd2, 1'b1, 32'h3000_0C0F, 1'b0);
            pipe.idle();
            cmp("exc_valid", 32'h1, {31'h0, exc_valid});
            cmp("exc_code", 32'h1A, {27'h0, exc_code});
            pipe.idle();
            chk_ctl(32'h0010_02A0);
            cmp("exc_code", 32'h0, {27'h0, exc_code});
        end
        chk_acc(32'h3000_1234, 32'h3000_1234);
        // Second reset in mid-run clears register and accumulators
        rst_b = 1'b0;
        pipe.idle();
        chk_ctl(32'h0);
        chk_acc(32'h0, 32'h0);
        rst_b = 1'b1;
        pipe.issue(5'h01, 2'd0, 1'b0, 32'hFFFF_FFFF, 1'b1);
        pipe.idle();
        chk_ctl(32'h0FFF_7FBF);
        give_verdict();
    end
endmodule // tb_dsp_accumulator_control_state
